// file: hw/dpr_pkg.sv
// shared constants and carrier types for the per-port ram indirect access block
package dpr_pkg;

  localparam int unsigned SLOT_W = 7;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SLOTS  = 128;

  // host register indices on the register port
  localparam logic [0:0] REG_SELECT = 1'h0;
  localparam logic [0:0] REG_DATA   = 1'h1;

  // port_ram_indirect_select fields
  localparam int unsigned SEL_SLOT_CHANNEL_ID_LSB = 0;
  localparam int unsigned SEL_PAGE_LSB = 8;
  localparam int unsigned SEL_DIR_BIT  = 14;
  localparam int unsigned SEL_BUSY_BIT = 15;

  localparam logic [1:0] PAGE_BYTES   = 2'h0;
  localparam logic [1:0] PAGE_RXCFG   = 2'h1;
  localparam logic [1:0] PAGE_TXCFG   = 2'h2;
  localparam logic [1:0] PAGE_ILLEGAL = 2'h3;

  localparam logic        DIR_READ       = 1'h1;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  localparam logic [6:0]  SLOT_RESET     = 7'h00;
  localparam logic [6:0]  UNCH_SLOT      = 7'h00;
  localparam logic [7:0]  ALL_ONES       = 8'hFF;
  localparam logic [8:0]  HDLC_CHAN_BASE = 9'h001;

  // configuration entry fields
  localparam int unsigned CFG_CHAN_LSB   = 0;
  localparam int unsigned CFG_SEVEN      = 8;
  localparam int unsigned TX_FORCE_ONES  = 9;
  localparam int unsigned RX_LOCAL_LB    = 10;
  localparam int unsigned TX_NET_LB      = 11;
  localparam int unsigned RX_LOOP_SEARCH = 12;
  localparam int unsigned CFG_TESTER     = 14;
  localparam int unsigned CFG_ENABLE     = 15;

  // byte store entry fields
  localparam int unsigned STORE_RX_LSB = 0;
  localparam int unsigned STORE_TX_LSB = 8;

  typedef enum logic [1:0] {ENG_IDLE, ENG_READ_ISSUE, ENG_READ_TAKE, ENG_WRITE} dpr_eng_e;

  typedef struct packed {
    logic        valid;
    logic [6:0]  slot;
    logic [7:0]  rx_byte;
    logic [7:0]  hdlc_byte;
    logic [7:0]  tester_byte;
  } dpr_slot_in_s;

  typedef struct packed {
    logic        valid;
    logic [8:0]  chan;
    logic [7:0]  data;
    logic        seven;
  } dpr_lane_s;

  typedef struct packed {
    dpr_lane_s   rx_hdlc;
    dpr_lane_s   rx_tester;
    dpr_lane_s   loop_search;
    dpr_lane_s   tx;
  } dpr_slot_out_s;

  // hdlc channel number k selects channel k+1
  function automatic logic [8:0] hdlc_chan(input logic [7:0] num);
    hdlc_chan = {1'b0, num} + HDLC_CHAN_BASE;
  endfunction

endpackage

// file: hw/dpr_word_mem.sv
// two-port word memory with registered read data
`timescale 1ns/1ps
module dpr_word_mem
  import dpr_pkg::*;
#(
  parameter int unsigned DEPTH = SLOTS,
  parameter int unsigned AW    = SLOT_W,
  parameter int unsigned W     = WORD_W
) (
  input  wire logic          i_clk,
  input  wire logic [AW-1:0] i_a_addr,
  input  wire logic          i_a_we,
  input  wire logic [W-1:0]  i_a_wdata,
  output logic      [W-1:0]  o_a_rdata,
  input  wire logic [AW-1:0] i_b_addr,
  input  wire logic          i_b_we,
  input  wire logic [W-1:0]  i_b_wdata,
  output logic      [W-1:0]  o_b_rdata
);

  logic [W-1:0] mem [DEPTH];

  // port b wins when both write one word
  always_ff @(posedge i_clk) begin
    if (i_a_we && !(i_b_we && i_b_addr == i_a_addr)) begin
      mem[i_a_addr] <= i_a_wdata;
    end
    if (i_b_we) begin
      mem[i_b_addr] <= i_b_wdata;
    end
    o_a_rdata <= mem[i_a_addr];
    o_b_rdata <= mem[i_b_addr];
  end

endmodule

// file: hw/dpr_slot_path.sv
// per-ds0 receive and transmit steering from the configuration entries
`timescale 1ns/1ps
module dpr_slot_path
  import dpr_pkg::*;
(
  input  wire logic          i_rx_unch,
  input  wire logic          i_tx_unch,
  input  dpr_slot_in_s       i_slot,
  input  wire logic [15:0]   i_rx_cfg,
  input  wire logic [15:0]   i_tx_cfg,
  input  wire logic [15:0]   i_store,
  output dpr_slot_out_s      o_out,
  output logic      [15:0]  o_store
);

  logic       rx_seven;
  logic       tx_seven;
  logic       local_lb;
  logic [7:0] tx_src;
  logic       tx_hdlc;

  always_comb begin
    rx_seven = i_rx_cfg[CFG_SEVEN] && !i_rx_unch;
    tx_seven = i_tx_cfg[CFG_SEVEN] && !i_tx_unch;
    local_lb = i_rx_cfg[RX_LOCAL_LB] && i_rx_cfg[CFG_ENABLE] && !i_rx_cfg[CFG_SEVEN];
    o_out = '0;
    // receive toward hdlc
    o_out.rx_hdlc.valid = i_slot.valid && i_rx_cfg[CFG_ENABLE];
    o_out.rx_hdlc.chan  = hdlc_chan(i_rx_cfg[CFG_CHAN_LSB +: 8]);
    o_out.rx_hdlc.data  = local_lb ? i_store[STORE_TX_LSB +: 8] : i_slot.rx_byte;
    o_out.rx_hdlc.seven = rx_seven;
    // receive toward the tester, open even for a disabled ds0
    o_out.rx_tester.valid = i_slot.valid && i_rx_cfg[CFG_TESTER];
    o_out.rx_tester.data  = i_slot.rx_byte;
    o_out.rx_tester.seven = rx_seven;
    // loop pattern search always sees all eight bits
    o_out.loop_search.valid = i_slot.valid && (i_rx_cfg[RX_LOOP_SEARCH] || i_rx_unch);
    o_out.loop_search.data  = i_slot.rx_byte;
    // transmit source priority
    tx_hdlc = 1'b0;
    if (i_tx_cfg[TX_NET_LB]) begin
      tx_src = i_store[STORE_RX_LSB +: 8];
    end else if (i_tx_cfg[CFG_TESTER]) begin
      tx_src = i_slot.tester_byte;
    end else if (i_tx_cfg[TX_FORCE_ONES]) begin
      tx_src = ALL_ONES;
    end else if (i_tx_cfg[CFG_ENABLE]) begin
      tx_src  = i_slot.hdlc_byte;
      tx_hdlc = 1'b1;
    end else begin
      tx_src = ALL_ONES;
    end
    if (tx_seven && !i_tx_cfg[TX_NET_LB]) begin
      tx_src[0] = 1'b1;
    end
    o_out.tx.valid = i_slot.valid && tx_hdlc;
    o_out.tx.chan  = hdlc_chan(i_tx_cfg[CFG_CHAN_LSB +: 8]);
    o_out.tx.data  = tx_src;
    o_out.tx.seven = tx_seven;
    o_store = {tx_src, i_slot.rx_byte};
  end

endmodule

// file: hw/dpr_port_ram.sv
// per-port ram with host indirect access and the ds0 layer 1 slot pipeline
`timescale 1ns/1ps
module dpr_port_ram
  import dpr_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  input  wire logic [0:0]    i_reg_addr,
  input  wire logic [15:0]   i_reg_wdata,
  output logic      [15:0]   o_reg_rdata,
  output logic               o_busy,
  input  wire logic          i_rx_unch,
  input  wire logic          i_tx_unch,
  input  dpr_slot_in_s       i_slot,
  output dpr_lane_s          o_rx_hdlc,
  output dpr_lane_s          o_rx_tester,
  output dpr_lane_s          o_loop_search,
  output dpr_lane_s          o_tx
);

  typedef struct packed {
    dpr_eng_e      eng;
    logic [6:0]    slot_id;
    logic [1:0]    page;
    logic          dir;
    logic [15:0]   data;
    logic [15:0]   rdata;
    dpr_slot_in_s  p1;
    dpr_slot_out_s out;
  } dpr_state_s;

  dpr_state_s    st_r;
  dpr_state_s    st_nxt;

  logic [15:0]   host_rdata [3];
  logic [15:0]   slot_rdata [3];
  logic [2:0]    host_we;
  logic [6:0]    cfg_addr;
  logic [6:0]    store_addr;
  logic          rx_cfg_use0;
  logic          tx_cfg_use0;
  logic [6:0]    rx_cfg_addr;
  logic [6:0]    tx_cfg_addr;
  dpr_slot_out_s path_out;
  logic [15:0]   path_store;
  logic [15:0]   sel_word;
  logic [15:0]   host_word;

  assign rx_cfg_use0 = i_rx_unch;
  assign tx_cfg_use0 = i_tx_unch;
  assign cfg_addr    = i_slot.slot;
  assign rx_cfg_addr = rx_cfg_use0 ? UNCH_SLOT : cfg_addr;
  assign tx_cfg_addr = tx_cfg_use0 ? UNCH_SLOT : cfg_addr;
  // the byte store is written back one cycle after the slot strobe
  assign store_addr  = st_r.p1.valid ? st_r.p1.slot : i_slot.slot;

  always_comb begin
    host_we = 3'h0;
    if (st_r.eng == ENG_WRITE) begin
      unique case (st_r.page)
        PAGE_BYTES: host_we = 3'h1;
        PAGE_RXCFG: host_we = 3'h2;
        PAGE_TXCFG: host_we = 3'h4;
        default:    host_we = 3'h0;
      endcase
    end
  end

  dpr_word_mem u_bytes (
    .i_clk     (i_clk),
    .i_a_addr  (st_r.slot_id),
    .i_a_we    (host_we[0]),
    .i_a_wdata (st_r.data),
    .o_a_rdata (host_rdata[0]),
    .i_b_addr  (store_addr),
    .i_b_we    (st_r.p1.valid),
    .i_b_wdata (path_store),
    .o_b_rdata (slot_rdata[0])
  );

  dpr_word_mem u_rx_cfg (
    .i_clk     (i_clk),
    .i_a_addr  (st_r.slot_id),
    .i_a_we    (host_we[1]),
    .i_a_wdata (st_r.data),
    .o_a_rdata (host_rdata[1]),
    .i_b_addr  (rx_cfg_addr),
    .i_b_we    (1'b0),
    .i_b_wdata (DATA_RESET),
    .o_b_rdata (slot_rdata[1])
  );

  dpr_word_mem u_tx_cfg (
    .i_clk     (i_clk),
    .i_a_addr  (st_r.slot_id),
    .i_a_we    (host_we[2]),
    .i_a_wdata (st_r.data),
    .o_a_rdata (host_rdata[2]),
    .i_b_addr  (tx_cfg_addr),
    .i_b_we    (1'b0),
    .i_b_wdata (DATA_RESET),
    .o_b_rdata (slot_rdata[2])
  );

  dpr_slot_path u_path (
    .i_rx_unch (i_rx_unch),
    .i_tx_unch (i_tx_unch),
    .i_slot    (st_r.p1),
    .i_rx_cfg  (slot_rdata[1]),
    .i_tx_cfg  (slot_rdata[2]),
    .i_store   (slot_rdata[0]),
    .o_out     (path_out),
    .o_store   (path_store)
  );

  always_comb begin
    sel_word = '0;
    sel_word[SEL_SLOT_CHANNEL_ID_LSB +: 7] = st_r.slot_id;
    sel_word[SEL_PAGE_LSB +: 2] = st_r.page;
    sel_word[SEL_DIR_BIT]       = st_r.dir;
    sel_word[SEL_BUSY_BIT]      = (st_r.eng != ENG_IDLE);
    host_word = (st_r.page == PAGE_TXCFG) ? host_rdata[2] :
                (st_r.page == PAGE_RXCFG) ? host_rdata[1] : host_rdata[0];
  end

  always_comb begin
    st_nxt     = st_r;
    st_nxt.p1  = i_slot;
    st_nxt.out = path_out;
    if (i_reg_rd) begin
      st_nxt.rdata = (i_reg_addr == REG_SELECT) ? sel_word : st_r.data;
    end
    unique case (st_r.eng)
      ENG_IDLE: begin
        if (i_reg_wr && i_reg_addr == REG_DATA) begin
          st_nxt.data = i_reg_wdata;
        end
        if (i_reg_wr && i_reg_addr == REG_SELECT) begin
          st_nxt.slot_id = i_reg_wdata[SEL_SLOT_CHANNEL_ID_LSB +: 7];
          st_nxt.page    = i_reg_wdata[SEL_PAGE_LSB +: 2];
          st_nxt.dir     = i_reg_wdata[SEL_DIR_BIT];
          if (i_reg_wdata[SEL_PAGE_LSB +: 2] == PAGE_ILLEGAL) begin
            st_nxt.eng = ENG_IDLE;
          end else if (i_reg_wdata[SEL_DIR_BIT] == DIR_READ) begin
            st_nxt.eng = ENG_READ_ISSUE;
          end else begin
            st_nxt.eng = ENG_WRITE;
          end
        end
      end
      ENG_READ_ISSUE: begin
        st_nxt.eng = ENG_READ_TAKE;
      end
      ENG_READ_TAKE: begin
        st_nxt.data = host_word;
        st_nxt.eng  = ENG_IDLE;
      end
      ENG_WRITE: begin
        st_nxt.eng = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r         <= '0;
      st_r.eng     <= ENG_IDLE;
      st_r.slot_id <= SLOT_RESET;
      st_r.page    <= PAGE_BYTES;
      st_r.data    <= DATA_RESET;
      st_r.rdata   <= DATA_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata   = st_r.rdata;
  assign o_busy        = (st_r.eng != ENG_IDLE);
  assign o_rx_hdlc     = st_r.out.rx_hdlc;
  assign o_rx_tester   = st_r.out.rx_tester;
  assign o_loop_search = st_r.out.loop_search;
  assign o_tx          = st_r.out.tx;

endmodule

// file: test/dpr_host_model.sv
// host model that reaches the port ram registers
`timescale 1ns/1ps
module dpr_host_model
  import dpr_pkg::*;
(
  input  wire logic        i_clk,
  output logic             o_wr,
  output logic             o_rd,
  output logic [0:0]       o_addr,
  output logic [15:0]      o_wdata,
  input  wire logic [15:0] i_rdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = REG_SELECT;
    o_wdata = 16'h0000;
  end
  // one write pulse; the bench waits for busy low after each select write before the next access
  task automatic wr(input logic [0:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [0:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

// file: test/dpr_port_ram_asserts.sv
// concurrent checks on the port ram ports
`timescale 1ns/1ps
module dpr_port_ram_asserts
  import dpr_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [0:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        o_busy,
  input wire logic        i_rx_unch,
  input wire logic        i_tx_unch,
  input dpr_slot_in_s     i_slot,
  input dpr_lane_s        o_rx_hdlc,
  input dpr_lane_s        o_rx_tester,
  input dpr_lane_s        o_loop_search,
  input dpr_lane_s        o_tx
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic sel;
  logic ok;
  assign sel = i_reg_wr && i_reg_addr == REG_SELECT && !o_busy;
  assign ok = i_reg_wdata[9:8] != PAGE_ILLEGAL;
  read_start_a: assert property (sel && ok && i_reg_wdata[14] |=> o_busy[*2])
    else $error("read busy short");
  read_done_a: assert property (sel && ok && i_reg_wdata[14] |=> ##2 !o_busy)
    else $error("read busy long");
  write_busy_a: assert property (sel && ok && !i_reg_wdata[14] |=> o_busy ##1 !o_busy)
    else $error("write busy bad");
  illegal_page_a: assert property (sel && !ok |=> !o_busy)
    else $error("illegal page started");
  busy_bit_a: assert property (i_reg_rd && i_reg_addr == REG_SELECT |=> o_reg_rdata[15] == $past(o_busy))
    else $error("busy bit bad");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
  hdlc_chan_a: assert property (o_rx_hdlc.valid |-> o_rx_hdlc.chan != 9'h000)
    else $error("channel zero");
  search_full_a: assert property (o_loop_search.valid |-> !o_loop_search.seven && $past(i_slot.valid, 2))
    else $error("search lane bad");
  lane_time_a: assert property (o_rx_hdlc.valid || o_rx_tester.valid |-> $past(i_slot.valid, 2))
    else $error("lane timing bad");
  tx_seven_a: assert property (o_tx.valid && o_tx.seven |-> o_tx.data[0])
    else $error("tx lsb not one");
  cover property (sel && i_reg_wdata[14]);
  cover property (sel && !i_reg_wdata[14]);
  cover property (o_tx.valid);
endmodule
bind dpr_port_ram dpr_port_ram_asserts dpr_port_ram_asserts_i (.i_clk, .i_rst_b, .i_reg_wr, .i_reg_rd,
  .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_busy, .i_rx_unch, .i_tx_unch, .i_slot, .o_rx_hdlc,
  .o_rx_tester, .o_loop_search, .o_tx);

// file: test/dpr_port_ram_tb.sv
// self-checking bench for the port ram block
`timescale 1ns/1ps
module dpr_port_ram_tb;
  import dpr_pkg::*;
  logic         i_clk;
  logic         i_rst_b;
  logic         wr;
  logic         rd;
  logic [0:0]   ad;
  logic [15:0]  wd;
  logic [15:0]  rdat;
  logic         busy;
  dpr_slot_in_s i_slot;
  dpr_lane_s    rxh;
  dpr_lane_s    rxt;
  dpr_lane_s    lps;
  dpr_lane_s    tx;
  logic [15:0]  v;
  logic [6:0]   ch;
  logic         rx_unch;
  logic         tx_unch;
  int           err_count;
  int           check_count;
  logic [15:0]  tcfg [6] = '{16'h8000, 16'h8100, 16'h8200, 16'hC200, 16'hCA00, 16'h0000};
  logic [7:0]   texp [6] = '{8'h96, 8'h97, 8'hFF, 8'h3C, 8'h5A, 8'hFF};
  dpr_port_ram dpr_port_ram_i (.i_clk, .i_rst_b, .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(ad),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_busy(busy), .i_rx_unch(rx_unch), .i_tx_unch(tx_unch),
    .i_slot, .o_rx_hdlc(rxh), .o_rx_tester(rxt), .o_loop_search(lps), .o_tx(tx));
  dpr_host_model dpr_host_model_i (.i_clk, .o_wr(wr), .o_rd(rd), .o_addr(ad), .o_wdata(wd), .i_rdata(rdat));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle();
    for (int n = 0; n < 10; n++) begin
      @(negedge i_clk);
      if (busy === 1'b0) return;
    end
    err_count++;
    $display("mismatch at %0t: busy stuck", $time);
    end_sim();
  endtask
  task automatic acc(input logic [1:0] pg, input logic [6:0] c, input logic dir, input logic [15:0] d);
    if (!dir) dpr_host_model_i.wr(REG_DATA, d);
    dpr_host_model_i.wr(REG_SELECT, {1'b0, dir, 4'h0, pg, 1'b0, c});
    idle();
    if (dir) dpr_host_model_i.rd(REG_DATA, v);
  endtask
  task automatic send(input logic [7:0] rb);
    @(negedge i_clk);
    i_slot = '{1'b1, 7'h03, rb, 8'h96, 8'h3C};
    @(negedge i_clk);
    i_slot.valid = 1'b0;
    // lane valid stands for one cycle only, from the next edge, so the caller looks at it right after this wait
    @(negedge i_clk);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    err_count = 0;
    check_count = 0;
    i_rst_b = 1'b0;
    i_slot = '0;
    rx_unch = 1'b0;
    tx_unch = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    dpr_host_model_i.rd(REG_SELECT, v);
    chk(v, 16'h0000);
    dpr_host_model_i.rd(REG_DATA, v);
    chk(v, DATA_RESET);
    $display("reset test done");
    for (int p = 1; p < 3; p++) begin
      for (int s = 0; s < 2; s++) begin
        ch = s ? 7'h7F : 7'h00;
        acc(p[1:0], ch, 1'b0, {1'b1, ch, 6'h15, p[1:0]});
        acc(p[1:0], ch, 1'b1, 16'h0000);
        chk(v, {1'b1, ch, 6'h15, p[1:0]});
      end
    end
    acc(PAGE_ILLEGAL, 7'h00, 1'b0, 16'h1234);
    acc(PAGE_RXCFG, 7'h00, 1'b1, 16'h0000);
    chk(v, 16'h8055);
    $display("access test done");
    acc(PAGE_RXCFG, 7'h03, 1'b0, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      acc(PAGE_TXCFG, 7'h03, 1'b0, tcfg[k]);
      send(8'h5A);
      chk({8'h00, tx.data}, {8'h00, texp[k]});
      chk({15'h0, tx.valid}, {15'h0, k < 2});
    end
    chk({15'h0, tx.valid}, 16'h0000);
    acc(PAGE_BYTES, 7'h03, 1'b1, 16'h0000);
    chk(v, 16'hFF5A);
    $display("transmit test done");
    acc(PAGE_RXCFG, 7'h03, 1'b0, 16'h80FF);
    send(8'h5A);
    chk({rxh.valid, 6'h00, rxh.chan}, 16'h8100);
    chk({rxh.seven, 7'h00, rxh.data}, 16'h005A);
    acc(PAGE_RXCFG, 7'h03, 1'b0, 16'h5100);
    send(8'hC3);
    chk({rxh.valid, rxt.valid, rxt.seven, lps.valid, lps.seven, 3'h0, lps.data}, 16'h70C3);
    chk({9'h000, rxt.data[7:1]}, 16'h0061);
    acc(PAGE_RXCFG, 7'h03, 1'b0, 16'h8400);
    send(8'h11);
    chk({8'h00, rxh.data}, 16'h00FF);
    acc(PAGE_RXCFG, 7'h03, 1'b0, 16'h8500);
    send(8'h11);
    chk({9'h000, rxh.data[7:1]}, 16'h0008);
    $display("receive test done");
    rx_unch = 1'b1;
    tx_unch = 1'b1;
    send(8'h22);
    chk({rxh.valid, lps.valid, 5'h00, rxh.chan}, 16'hC056);
    chk({8'h00, rxh.data}, 16'h0022);
    chk({tx.valid, 6'h00, tx.chan}, 16'h8057);
    $display("unchannelized test done");
    end_sim();
  end
endmodule
